// File: hdl/tsdio_pkg.sv
// package: constants, register map and types of the timestamped digital io
package tsdio_pkg;

    localparam int unsigned NUM_CH      = 32;
    localparam int unsigned GROUP_W     = 8;
    localparam int unsigned NUM_GROUPS  = 4;
    localparam int unsigned TIME_W      = 32;
    localparam int unsigned ENTRY_W     = 64;
    localparam int unsigned FIFO_DEPTH  = 2048;
    localparam int unsigned PTR_W       = 11;
    localparam int unsigned CNT_W       = 12;
    localparam int unsigned FILT_W      = 8;

    // time base: 4 ns clock steps a 5 ns stamp counter (200 MHz)
    localparam int unsigned CLK_PERIOD_PS  = 4000;
    localparam int unsigned STAMP_RES_PS   = 5000;
    localparam int unsigned PHASE_W        = 13;
    localparam logic [PHASE_W-1:0] PHASE_STEP  = PHASE_W'(CLK_PERIOD_PS);
    localparam logic [PHASE_W-1:0] PHASE_LIMIT = PHASE_W'(STAMP_RES_PS);

    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] DIR_OFFSET        = 8'h04;
    localparam logic [7:0] FILTER_OFFSET     = 8'h08;
    localparam logic [7:0] DIN_OFFSET        = 8'h0c;
    localparam logic [7:0] DOUT_OFFSET       = 8'h10;
    localparam logic [7:0] RISE_OFFSET       = 8'h14;
    localparam logic [7:0] FALL_OFFSET       = 8'h18;
    localparam logic [7:0] STATUS_OFFSET     = 8'h1c;
    localparam logic [7:0] FIFO_LEVEL_OFFSET = 8'h20;
    localparam logic [7:0] FIFO_TIME_OFFSET  = 8'h24;
    localparam logic [7:0] TIMER_OFFSET      = 8'h28;

    // control register fields
    localparam int unsigned CTRL_RECORD_BIT = 0;
    localparam int unsigned CTRL_START_BIT  = 1;
    localparam int unsigned CTRL_MODE_BIT   = 2;
    localparam int unsigned CTRL_CLEAR_BIT  = 3;

    // status register fields
    localparam int unsigned STAT_FULL_BIT   = 0;
    localparam int unsigned STAT_EMPTY_BIT  = 1;
    localparam int unsigned STAT_RUN_BIT    = 2;
    localparam int unsigned STAT_COUNT_LSB  = 16;

    // reset values
    localparam logic [2:0]            CTRL_RESET   = 3'h0;
    localparam logic [NUM_GROUPS-1:0] DIR_RESET    = 4'h0;
    localparam logic [FILT_W-1:0]     FILTER_RESET = 8'h00;
    localparam logic [NUM_CH-1:0]     DOUT_RESET   = 32'h0000_0000;

    typedef enum logic {
        MODE_RECORD   = 1'b0,
        MODE_PLAYBACK = 1'b1
    } fifo_mode_type;

    typedef enum logic [1:0] {
        BOOT_IDLE = 2'b00,
        BOOT_LOAD = 2'b01,
        BOOT_RUN  = 2'b10,
        BOOT_HALT = 2'b11
    } boot_state_type;

endpackage : tsdio_pkg

// File: hdl/entry_store.sv
// entry store: flip-flop fifo of level and time stamp pairs
`timescale 1ns/1ps
module entry_store
    import tsdio_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic               clear,
    input  wire logic               push,
    input  wire logic [ENTRY_W-1:0] push_data,
    input  wire logic               pop,
    output logic      [ENTRY_W-1:0] head_data,
    output logic                    full,
    output logic                    empty,
    output logic      [CNT_W-1:0]   count
);

    logic [ENTRY_W-1:0] mem_r [FIFO_DEPTH];
    logic [PTR_W-1:0]   wr_ptr_r;
    logic [PTR_W-1:0]   rd_ptr_r;
    logic [CNT_W-1:0]   count_r;
    logic               do_push;
    logic               do_pop;

    // a push into a full store or a pop from an empty one is dropped
    assign do_push   = push && !full;
    assign do_pop    = pop && !empty;
    assign full      = (count_r == CNT_W'(FIFO_DEPTH));
    assign empty     = (count_r == '0);
    assign count     = count_r;
    assign head_data = mem_r[rd_ptr_r];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            wr_ptr_r <= '0;
        end else if (do_push) begin
            wr_ptr_r <= wr_ptr_r + PTR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            rd_ptr_r <= '0;
        end else if (do_pop) begin
            rd_ptr_r <= rd_ptr_r + PTR_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || clear) begin
            count_r <= '0;
        end else if (do_push && !do_pop) begin
            count_r <= count_r + CNT_W'(1);
        end else if (do_pop && !do_push) begin
            count_r <= count_r - CNT_W'(1);
        end
    end

endmodule : entry_store

// File: hdl/timestamped_digital_io.sv
// timestamped digital io: direction groups, filters, edge log, playback
//
// Notes on behaviour
// - 32 channels, direction set per 8-channel group
// - reset: all groups inputs, drivers off
// - recording samples inputs at 200 MHz rate
// - each change pushes levels plus stamp; 2048 deep
// - host pops recorded entries from the fifo
// - per-channel rising and falling flags, readable
// - one filter per channel, common setting
// - filters disabled after reset
// - playback drives stored patterns at stored times
// - playback time resolution is 5 ns
// - fifo serves recording or playback, not both
// - processor port reads inputs and drives outputs
// - stored boot program loaded and started at reset
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module timestamped_digital_io
    import tsdio_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wr_data,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rd_data,
    // channel pins
    input  wire logic [NUM_CH-1:0] dio_in,
    output logic      [NUM_CH-1:0] dio_out,
    output logic      [NUM_CH-1:0] dio_oe_n,
    // on-module processor port
    output logic      [NUM_CH-1:0] cpu_in_levels,
    input  wire logic              cpu_out_wr,
    input  wire logic [NUM_CH-1:0] cpu_out_data,
    // boot loader handshake
    input  wire logic              boot_program_present,
    input  wire logic              boot_load_done,
    output logic                   boot_load_req,
    output logic                   cpu_run
);

    // channel mask of the groups set as outputs
    function automatic logic [NUM_CH-1:0] expand_dir(
        input logic [NUM_GROUPS-1:0] dir
    );
        logic [NUM_CH-1:0] mask;
        mask = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            mask[g*GROUP_W +: GROUP_W] = {GROUP_W{dir[g]}};
        end
        return mask;
    endfunction : expand_dir

    // sticky flags: a new event wins over a clear in the same cycle
    function automatic logic [NUM_CH-1:0] flag_update(
        input logic [NUM_CH-1:0] flags,
        input logic [NUM_CH-1:0] set,
        input logic [NUM_CH-1:0] clr
    );
        return (flags & ~clr) | set;
    endfunction : flag_update

    logic [NUM_GROUPS-1:0] group_direction_config_r;
    logic [FILT_W-1:0]     spike_filter_setup_r;
    logic                  edge_record_enable_r;
    logic                  timed_output_start_r;
    fifo_mode_type         fifo_mode_r;
    logic [NUM_CH-1:0]     dout_r;
    logic [NUM_CH-1:0]     rise_flags_r;
    logic [NUM_CH-1:0]     fall_flags_r;
    logic [TIME_W-1:0]     stage_time_r;
    logic [31:0]           rd_data_r;
    logic [PHASE_W-1:0]    phase_r;
    logic                  tick;
    logic [TIME_W-1:0]     stamp_r;
    logic [NUM_CH-1:0]     raw_r;
    logic [NUM_CH-1:0]     filt_r;
    logic [NUM_CH-1:0]     prev_r;
    logic [FILT_W-1:0]     stable_cnt_r [NUM_CH];
    logic                  sample_valid_r;
    boot_state_type        boot_state_r;

    logic [NUM_CH-1:0]     out_mask;
    logic [NUM_CH-1:0]     rise_now;
    logic [NUM_CH-1:0]     fall_now;
    logic                  change_now;
    logic                  wr_ctrl;
    logic                  fifo_clear;
    logic                  fifo_push;
    logic [ENTRY_W-1:0]    fifo_push_data;
    logic                  fifo_pop;
    logic [ENTRY_W-1:0]    fifo_head;
    logic                  fifo_full;
    logic                  fifo_empty;
    logic [CNT_W-1:0]      fifo_count;
    logic                  play_due;
    logic                  host_pop;
    logic                  host_push;
    logic [TIME_W-1:0]     head_time;
    logic [NUM_CH-1:0]     head_level;

    assign out_mask   = expand_dir(group_direction_config_r);
    assign wr_ctrl    = reg_wr && (reg_addr == CTRL_OFFSET);
    assign head_time  = fifo_head[ENTRY_W-1 -: TIME_W];
    assign head_level = fifo_head[NUM_CH-1:0];

    // pins: drivers enabled only for output groups (active low)
    assign dio_oe_n      = ~out_mask;
    assign dio_out       = dout_r;
    assign cpu_in_levels = filt_r;
    assign reg_rd_data   = rd_data_r;

    // ---------------- time base ----------------
    // 5 ns ticks from a 4 ns clock: fractional phase, jitter of one clock
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_r <= '0;
        end else if (phase_r + PHASE_STEP >= PHASE_LIMIT) begin
            phase_r <= phase_r + PHASE_STEP - PHASE_LIMIT;
        end else begin
            phase_r <= phase_r + PHASE_STEP;
        end
    end

    assign tick = (phase_r + PHASE_STEP >= PHASE_LIMIT);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stamp_r <= '0;
        end else if (tick) begin
            stamp_r <= stamp_r + TIME_W'(1);
        end
    end

    // ---------------- control registers ----------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            group_direction_config_r <= DIR_RESET;
        end else if (reg_wr && reg_addr == DIR_OFFSET) begin
            group_direction_config_r <= reg_wr_data[NUM_GROUPS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            spike_filter_setup_r <= FILTER_RESET;
        end else if (reg_wr && reg_addr == FILTER_OFFSET) begin
            spike_filter_setup_r <= reg_wr_data[FILT_W-1:0];
        end
    end

    // mode decides who owns the fifo; only one use is ever active
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            edge_record_enable_r <= CTRL_RESET[CTRL_RECORD_BIT];
            timed_output_start_r <= CTRL_RESET[CTRL_START_BIT];
            fifo_mode_r          <= fifo_mode_type'(CTRL_RESET[CTRL_MODE_BIT]);
        end else if (wr_ctrl) begin
            edge_record_enable_r <= reg_wr_data[CTRL_RECORD_BIT];
            timed_output_start_r <= reg_wr_data[CTRL_START_BIT];
            fifo_mode_r <= fifo_mode_type'(reg_wr_data[CTRL_MODE_BIT]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stage_time_r <= '0;
        end else if (reg_wr && reg_addr == FIFO_TIME_OFFSET) begin
            stage_time_r <= reg_wr_data;
        end
    end

    // ---------------- input filter ----------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            raw_r <= '0;
        end else if (tick) begin
            raw_r <= dio_in;
        end
    end

    // a level must hold for setting ticks before it passes; 0 = bypass
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_r <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                stable_cnt_r[i] <= '0;
            end
        end else if (tick) begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (spike_filter_setup_r == '0) begin
                    filt_r[i]       <= raw_r[i];
                    stable_cnt_r[i] <= '0;
                end else if (raw_r[i] == filt_r[i]) begin
                    stable_cnt_r[i] <= '0;
                end else if (stable_cnt_r[i] + FILT_W'(1)
                             >= spike_filter_setup_r) begin
                    filt_r[i]       <= raw_r[i];
                    stable_cnt_r[i] <= '0;
                end else begin
                    stable_cnt_r[i] <= stable_cnt_r[i] + FILT_W'(1);
                end
            end
        end
    end

    // ---------------- edge detection ----------------
    // first sample after reset only seeds prev from the reset filt, so inputs high at reset still log a rise
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_r         <= '0;
            sample_valid_r <= 1'b0;
        end else if (tick) begin
            prev_r         <= filt_r;
            sample_valid_r <= 1'b1;
        end
    end

    // output groups are masked so driven levels never log as edges
    assign rise_now   = (tick && sample_valid_r) ?
                        (filt_r & ~prev_r & ~out_mask) : '0;
    assign fall_now   = (tick && sample_valid_r) ?
                        (~filt_r & prev_r & ~out_mask) : '0;
    assign change_now = |(rise_now | fall_now);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rise_flags_r <= '0;
        end else begin
            rise_flags_r <= flag_update(rise_flags_r, rise_now,
                (reg_wr && reg_addr == RISE_OFFSET) ? reg_wr_data : '0);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fall_flags_r <= '0;
        end else begin
            fall_flags_r <= flag_update(fall_flags_r, fall_now,
                (reg_wr && reg_addr == FALL_OFFSET) ? reg_wr_data : '0);
        end
    end

    // ---------------- fifo ----------------
    assign fifo_clear = wr_ctrl && reg_wr_data[CTRL_CLEAR_BIT];
    assign host_pop   = reg_rd && reg_addr == FIFO_LEVEL_OFFSET
                        && fifo_mode_r == MODE_RECORD;
    assign host_push  = reg_wr && reg_addr == FIFO_LEVEL_OFFSET
                        && fifo_mode_r == MODE_PLAYBACK;

    // due when the stamp has reached or passed the stored time
    assign play_due = fifo_mode_r == MODE_PLAYBACK && timed_output_start_r
                      && !fifo_empty
                      && $signed(stamp_r - head_time) >= 0;

    // recording while full drops the change; full flag tells software
    always_comb begin
        fifo_push      = 1'b0;
        fifo_push_data = '0;
        if (fifo_mode_r == MODE_RECORD) begin
            fifo_push      = edge_record_enable_r && change_now;
            fifo_push_data = {stamp_r, filt_r};
        end else begin
            fifo_push      = host_push;
            fifo_push_data = {stage_time_r, reg_wr_data};
        end
    end

    assign fifo_pop = host_pop || play_due;

    entry_store u_store (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clear     (fifo_clear),
        .push      (fifo_push),
        .push_data (fifo_push_data),
        .pop       (fifo_pop),
        .head_data (fifo_head),
        .full      (fifo_full),
        .empty     (fifo_empty),
        .count     (fifo_count)
    );

    // ---------------- output levels ----------------
    // playback beats the processor, which beats the host, in one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dout_r <= DOUT_RESET;
        end else if (play_due) begin
            dout_r <= head_level;
        end else if (cpu_out_wr) begin
            dout_r <= cpu_out_data;
        end else if (reg_wr && reg_addr == DOUT_OFFSET) begin
            dout_r <= reg_wr_data;
        end
    end

    // ---------------- boot sequence ----------------
    // strap is looked at only after reset release, in idle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_state_r <= BOOT_IDLE;
        end else begin
            unique case (boot_state_r)
                BOOT_IDLE: begin
                    boot_state_r <= boot_program_present ?
                                    BOOT_LOAD : BOOT_HALT;
                end
                BOOT_LOAD: begin
                    if (boot_load_done) begin
                        boot_state_r <= BOOT_RUN;
                    end
                end
                BOOT_RUN: begin
                    boot_state_r <= BOOT_RUN;
                end
                BOOT_HALT: begin
                    boot_state_r <= BOOT_HALT;
                end
            endcase
        end
    end

    assign boot_load_req = (boot_state_r == BOOT_LOAD);
    assign cpu_run       = (boot_state_r == BOOT_RUN);

    // ---------------- read port ----------------
    // data stand for exactly the cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (sys_rst || !reg_rd) begin
            rd_data_r <= '0;
        end else begin
            unique case (reg_addr)
                CTRL_OFFSET: begin
                    rd_data_r <= 32'({fifo_mode_r, timed_output_start_r,
                                      edge_record_enable_r});
                end
                DIR_OFFSET:        rd_data_r <= 32'(group_direction_config_r);
                FILTER_OFFSET:     rd_data_r <= 32'(spike_filter_setup_r);
                DIN_OFFSET:        rd_data_r <= filt_r;
                DOUT_OFFSET:       rd_data_r <= dout_r;
                RISE_OFFSET:       rd_data_r <= rise_flags_r;
                FALL_OFFSET:       rd_data_r <= fall_flags_r;
                STATUS_OFFSET: begin
                    rd_data_r <= '0;
                    rd_data_r[STAT_FULL_BIT] <=
                        fifo_full && fifo_mode_r == MODE_RECORD;
                    rd_data_r[STAT_EMPTY_BIT] <=
                        fifo_empty && fifo_mode_r == MODE_PLAYBACK;
                    rd_data_r[STAT_RUN_BIT] <= cpu_run;
                    rd_data_r[STAT_COUNT_LSB +: CNT_W] <= fifo_count;
                end
                FIFO_LEVEL_OFFSET: rd_data_r <= head_level;
                FIFO_TIME_OFFSET:  rd_data_r <= head_time;
                TIMER_OFFSET:      rd_data_r <= stamp_r;
                default:           rd_data_r <= '0;
            endcase
        end
    end

endmodule : timestamped_digital_io

// File: test/tsdio_checker_asserts.sv
// checker: port-level properties of the timestamped digital io
`timescale 1ns/1ps
module tsdio_checker
    import tsdio_pkg::*;
(
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wr_data,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rd_data,
    input wire logic [NUM_CH-1:0] dio_out,
    input wire logic [NUM_CH-1:0] dio_oe_n,
    input wire logic [NUM_CH-1:0] cpu_in_levels,
    input wire logic              cpu_out_wr,
    input wire logic [NUM_CH-1:0] cpu_out_data,
    input wire logic              boot_program_present,
    input wire logic              boot_load_done,
    input wire logic              boot_load_req,
    input wire logic              cpu_run
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_rd_idle; !$past(reg_rd) |-> reg_rd_data == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_dir; reg_wr && reg_addr == DIR_OFFSET |=> dio_oe_n == ~{
        {8{$past(reg_wr_data[3])}}, {8{$past(reg_wr_data[2])}},
        {8{$past(reg_wr_data[1])}}, {8{$past(reg_wr_data[0])}}}; endproperty
    a_dir: assert property (p_dir) else $error("group enables wrong");
    property p_rst; $fell(sys_rst) |-> dio_oe_n == {NUM_CH{1'b1}}
        && dio_out == '0 && !cpu_run && !boot_load_req; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_boot_req;
        $fell(sys_rst) && boot_program_present ##1 1'b1 |-> boot_load_req;
    endproperty
    a_boot_req: assert property (p_boot_req) else $error("no load request");
    property p_boot_run; boot_load_req && boot_load_done |=>
        cpu_run && !boot_load_req; endproperty
    a_boot_run: assert property (p_boot_run) else $error("cpu not started");
    property p_run_hold; cpu_run |=> cpu_run; endproperty
    a_run_hold: assert property (p_run_hold) else $error("cpu run dropped");
    property p_cpu_wr; cpu_out_wr |=> dio_out == $past(cpu_out_data); endproperty
    a_cpu_wr: assert property (p_cpu_wr) else $error("cpu write lost");
    property p_din; reg_rd && reg_addr == DIN_OFFSET |=>
        reg_rd_data == $past(cpu_in_levels); endproperty
    a_din: assert property (p_din) else $error("host and cpu levels differ");
    property p_unmapped; reg_rd && reg_addr > TIMER_OFFSET |=>
        reg_rd_data == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
endmodule : tsdio_checker

// File: test/boot_loader_model.sv
// partner: boot loader that answers a load request after a delay
`timescale 1ns/1ps
module boot_loader_model #(
    parameter int LOAD_CYCLES = 6
) (
    input  wire logic clk,
    input  wire logic boot_load_req,
    output logic      boot_load_done
);
    int cnt_r = 0;
    initial boot_load_done = 1'b0;
    // done only while asked, so a stale done never starts the cpu
    always @(posedge clk) begin
        if (!boot_load_req) begin
            cnt_r <= 0;
            boot_load_done <= 1'b0;
        end else if (cnt_r == LOAD_CYCLES) begin
            boot_load_done <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule : boot_loader_model

// File: test/timestamped_digital_io_tb.sv
// testbench: self-checking run over the timestamped digital io
`timescale 1ns/1ps
module timestamped_digital_io_tb
    import tsdio_pkg::*;
;
    logic              clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [7:0]        reg_addr = 8'h00;
    logic [31:0]       reg_wr_data = 32'h0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [31:0]       reg_rd_data;
    logic [NUM_CH-1:0] dio_in = '0;
    logic [NUM_CH-1:0] dio_out;
    logic [NUM_CH-1:0] dio_oe_n;
    logic [NUM_CH-1:0] cpu_in_levels;
    logic              cpu_out_wr = 1'b0;
    logic [NUM_CH-1:0] cpu_out_data = '0;
    logic              boot_load_done;
    logic              boot_load_req;
    logic              cpu_run;
    logic              boot_present = 1'b1;
    int                mismatches = 0;
    int                tests_run = 0;
    int                cyc = 0;
    logic [31:0]       a, b, v, t, s1, s2;

    always #2 clk = ~clk;

    timestamped_digital_io dut_u (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe_n(dio_oe_n),
        .cpu_in_levels(cpu_in_levels), .cpu_out_wr(cpu_out_wr),
        .cpu_out_data(cpu_out_data), .boot_program_present(boot_present),
        .boot_load_done(boot_load_done), .boot_load_req(boot_load_req),
        .cpu_run(cpu_run));
    boot_loader_model ldr_u (.clk(clk), .boot_load_req(boot_load_req),
        .boot_load_done(boot_load_done));

    function automatic logic [31:0] oe_exp(input logic [3:0] dir);
        for (int g = 0; g < 4; g++) oe_exp[8*g +: 8] = dir[g] ? 8'h00 : 8'hff;
    endfunction : oe_exp

    task automatic chk(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wr_data <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] ad, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rd_data;
    endtask : rd

    task automatic rdchk(input logic [7:0] ad, input logic [31:0] e,
                         input string w);
        logic [31:0] d;
        rd(ad, d);
        chk(d, e, w);
    endtask : rdchk

    task automatic close_out();
        $display("compared %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    // ceiling well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            $display("mismatch at %0t: timeout", $time);
            close_out();
        end
    end

    initial begin
        void'($urandom(42));
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clk);
        chk(dio_oe_n, '1, "oe after reset");
        rdchk(DIR_OFFSET, 32'h0, "dir reset");
        rdchk(FILTER_OFFSET, 32'h0, "filter reset");
        chk({31'h0, cpu_run}, 32'h1, "cpu run");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            wr(DIR_OFFSET, 32'(i));
            #1 chk(dio_oe_n, oe_exp(4'(i)), "group oe");
        end
        $display("test direction done");
        wr(DIR_OFFSET, 32'h0);
        wr(CTRL_OFFSET, 32'h8);
        wr(CTRL_OFFSET, 32'h1);
        a = $urandom | 32'h1;
        b = a ^ ($urandom | 32'h100);
        @(posedge clk);
        dio_in <= a;
        // a multiple of 5 clocks keeps the stamp phase identical
        repeat (30) @(posedge clk);
        dio_in <= b;
        repeat (30) @(posedge clk);
        rdchk(STATUS_OFFSET, 32'h0002_0004, "two entries");
        rd(FIFO_TIME_OFFSET, s1);
        rdchk(FIFO_LEVEL_OFFSET, a, "first level");
        rd(FIFO_TIME_OFFSET, s2);
        rdchk(FIFO_LEVEL_OFFSET, b, "second level");
        chk(s2 - s1, 32'd24, "stamp rate");
        rdchk(STATUS_OFFSET, 32'h4, "popped empty");
        rdchk(DIN_OFFSET, b, "din");
        chk(cpu_in_levels, b, "cpu levels");
        rdchk(RISE_OFFSET, a | b, "rise");
        rdchk(FALL_OFFSET, a & ~b, "fall");
        wr(RISE_OFFSET, '1);
        rdchk(RISE_OFFSET, 32'h0, "rise cleared");
        $display("test record done");
        wr(CTRL_OFFSET, 32'h0);
        wr(FILTER_OFFSET, 32'h10);
        @(posedge clk);
        dio_in <= ~b;
        repeat (2) @(posedge clk);
        dio_in <= b;
        repeat (40) @(posedge clk);
        rdchk(DIN_OFFSET, b, "spike held off");
        @(posedge clk);
        dio_in <= ~b;
        repeat (60) @(posedge clk);
        rdchk(DIN_OFFSET, ~b, "steady change");
        $display("test filter done");
        wr(DIR_OFFSET, 32'hf);
        v = $urandom;
        wr(DOUT_OFFSET, ~v);
        #1 chk(dio_out, ~v, "host output");
        @(posedge clk);
        cpu_out_wr <= 1'b1;
        cpu_out_data <= v;
        @(posedge clk);
        cpu_out_wr <= 1'b0;
        #1 chk(dio_out, v, "cpu output");
        wr(CTRL_OFFSET, 32'hc);
        rd(TIMER_OFFSET, t);
        wr(FIFO_TIME_OFFSET, t + 32'd200);
        a = $urandom;
        wr(FIFO_LEVEL_OFFSET, a);
        rdchk(STATUS_OFFSET, 32'h0001_0004, "one pattern");
        wr(CTRL_OFFSET, 32'h6);
        repeat (175) @(posedge clk);
        chk(dio_out, v, "not yet due");
        for (int i = 0; i < 100 && dio_out !== a; i++) @(posedge clk);
        chk(dio_out, a, "pattern on time");
        rdchk(STATUS_OFFSET, 32'h6, "drained");
        wr(CTRL_OFFSET, 32'hc);
        for (int i = 0; i < 2049; i++) wr(FIFO_LEVEL_OFFSET, 32'(i));
        wr(CTRL_OFFSET, 32'h0);
        rdchk(STATUS_OFFSET, 32'h0800_0005, "full");
        rdchk(FIFO_LEVEL_OFFSET, 32'h0, "oldest kept");
        wr(8'hfc, '1);
        rdchk(8'hfc, 32'h0, "unmapped");
        @(posedge clk);
        sys_rst <= 1'b1;
        boot_present <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (20) @(posedge clk);
        chk(32'(cpu_run), 32'h0, "halted");
        $display("test playback done");
        close_out();
    end
endmodule : timestamped_digital_io_tb

bind timestamped_digital_io tsdio_checker chk_u (.clk(clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .dio_out(dio_out), .dio_oe_n(dio_oe_n),
    .cpu_in_levels(cpu_in_levels), .cpu_out_wr(cpu_out_wr),
    .cpu_out_data(cpu_out_data), .boot_program_present(boot_program_present),
    .boot_load_done(boot_load_done), .boot_load_req(boot_load_req),
    .cpu_run(cpu_run));
